// ==== rtl/uec_map.vh ====
// Purpose: register map, field positions and reset values of the enhanced feature control
// Assumes: one 8-bit register per aligned 32-bit Wishbone word
// Notes:
`ifndef UEC_MAP_VH
`define UEC_MAP_VH

`define UEC_OFS_SCRATCH   6'h00
`define UEC_OFS_FEATURE   6'h04
`define UEC_OFS_ENH_SEL   6'h08
`define UEC_OFS_TX_FILL   6'h0c
`define UEC_OFS_INT_EN    6'h10
`define UEC_OFS_FIFO_CTL  6'h14
`define UEC_OFS_MODEM_CTL 6'h18
`define UEC_OFS_INT_STAT  6'h1c
`define UEC_OFS_RESUME1   6'h20
`define UEC_OFS_RESUME2   6'h24
`define UEC_OFS_PAUSE1    6'h28
`define UEC_OFS_PAUSE2    6'h2c
`define UEC_OFS_TURN_DLY  6'h30
`define UEC_OFS_RX_TRIG   6'h34

`define UEC_RST_SCRATCH   8'hff
`define UEC_RST_ZERO      8'h00

`define UEC_FCT_IR_INV    4
`define UEC_FCT_HDX       5
`define UEC_ENH_SPECIAL   5
`define UEC_ENH_ENABLE    4
`define UEC_ENH_AUTO_RTS  6
`define UEC_ENH_AUTO_CTS  7
`define UEC_MCR_SEL_DTR   2
`define UEC_ST_SPECIAL    4
`define UEC_ST_PAUSE      5

`define UEC_MASK_IER      8'hf0
`define UEC_MASK_FCR      8'h30
`define UEC_MASK_MCR      8'he0
`define UEC_MASK_ISR      8'h30

`endif

// ==== rtl/uec_hyst.v ====
// Purpose: receive flow-control thresholds from trigger, table and hysteresis code
// Assumes: next-level thresholds for tables A-C come from the trigger table logic
// Notes: purely combinational; upper clips at 127, lower saturates at 0
`default_nettype none
module uec_hyst (
	input  wire [1:0] table_sel_i,
	input  wire [3:0] hyst_code_i,
	input  wire [6:0] trig_i,
	input  wire [6:0] next_up_i,
	input  wire [6:0] next_dn_i,
	output reg  [6:0] up_o,
	output reg  [6:0] dn_o
);

	// Character count for each hysteresis code
	function [6:0] hyst_chars;
		input [3:0] code;
		begin
			case (code)
			4'h0: hyst_chars = 7'h00;
			4'h1: hyst_chars = 7'h04;
			4'h2: hyst_chars = 7'h06;
			4'h3: hyst_chars = 7'h08;
			4'h4: hyst_chars = 7'h08;
			4'h5: hyst_chars = 7'h10;
			4'h6: hyst_chars = 7'h18;
			4'h7: hyst_chars = 7'h20;
			4'h8: hyst_chars = 7'h28;
			4'h9: hyst_chars = 7'h2c;
			4'ha: hyst_chars = 7'h30;
			4'hb: hyst_chars = 7'h34;
			4'hc: hyst_chars = 7'h0c;
			4'hd: hyst_chars = 7'h14;
			4'he: hyst_chars = 7'h1c;
			default: hyst_chars = 7'h24;
			endcase
		end
	endfunction

	reg [7:0] sum;
	reg [6:0] h;

	// Table D uses the field, other tables fall back to next levels
	always @* begin
		h   = hyst_chars(hyst_code_i);
		sum = {1'b0, trig_i} + {1'b0, h};
		if (table_sel_i == 2'b11) begin
			up_o = sum[7] ? 7'h7f : sum[6:0];
			dn_o = (trig_i > h) ? (trig_i - h) : 7'h00;
		end else begin
			up_o = next_up_i;
			dn_o = next_dn_i;
		end
	end

endmodule
`default_nettype wire

// ==== rtl/uec_ctrl.v ====
// Purpose: per-channel enhanced feature control with a Wishbone register slave
// Assumes: core-side strobes share sys_clk_i; pins are synchronised here
// Notes: trigger table contents, baud generator and FIFOs live in the core
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`include "uec_map.vh"
`default_nettype none
module uec_ctrl #(
	parameter FILL_MAX = 8'h40
) (
	input  wire        sys_clk_i,
	input  wire        rst_n_i,
	// Wishbone classic slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Transmit side of the core
	input  wire        tx_push_i,
	input  wire        tx_pop_i,
	input  wire        tx_busy_i,
	input  wire        tx_char_done_i,
	input  wire        bit_tick_i,
	output reg         tx_go_o,
	output reg         tx_irq_o,
	output reg  [1:0]  tx_flow_mode_o,
	// Receive side of the core
	input  wire        rx_valid_i,
	input  wire [7:0]  rx_char_i,
	input  wire [6:0]  rx_level_i,
	input  wire [6:0]  rx_next_up_i,
	input  wire [6:0]  rx_next_dn_i,
	output reg         rx_store_o,
	output reg  [7:0]  rx_store_data_o,
	output reg         rx_resume_o,
	output reg         rx_pause_o,
	output reg         rx_trig_o,
	// Register copies for the core
	output reg  [7:0]  int_en_o,
	output reg  [7:0]  fifo_ctl_o,
	output reg  [7:0]  modem_ctl_o,
	output reg  [1:0]  table_sel_o,
	// Pins
	input  wire        irda_rx_i,
	input  wire        cts_n_i,
	input  wire        dsr_n_i,
	output reg         irda_rx_o,
	output reg         rts_n_o,
	output reg         dtr_n_o
);

	localparam HD_IDLE = 2'd0;
	localparam HD_SEND = 2'd1;
	localparam HD_WAIT = 2'd2;

	localparam SQ_NONE   = 2'd0;
	localparam SQ_RESUME = 2'd1;
	localparam SQ_PAUSE  = 2'd2;

	// Merge protected and free bits of one register byte
	function [7:0] merge;
		input [7:0] old;
		input [7:0] upd;
		input [7:0] prot;
		input       unlock;
		begin
			merge = unlock ? upd : ((old & prot) | (upd & ~prot));
		end
	endfunction

	reg  [7:0] scratch_q;
	reg  [7:0] feature_q;
	reg  [7:0] enh_q;
	reg  [7:0] fill_q;
	reg  [7:0] ier_q;
	reg  [7:0] fcr_q;
	reg  [7:0] mcr_q;
	reg  [7:0] res1_q;
	reg  [7:0] res2_q;
	reg  [7:0] pau1_q;
	reg  [7:0] pau2_q;
	reg  [3:0] dly_q;
	reg  [6:0] trig_q;
	reg        spec_q;
	reg        pause_st_q;
	reg  [1:0] hd_q;
	reg  [3:0] hd_cnt_q;
	reg  [1:0] seq_q;
	reg        hold_q;
	reg  [2:0] sync1_q;
	reg  [2:0] sync2_q;
	reg  [31:0] rdat;

	wire [6:0] th_up;
	wire [6:0] th_dn;

	wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr      = req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];
	wire unlock  = enh_q[`UEC_ENH_ENABLE];
	wire hdx     = feature_q[`UEC_FCT_HDX];
	wire irda_s  = sync2_q[0];
	wire cts_s   = sync2_q[1];
	wire dsr_s   = sync2_q[2];
	wire sel_dtr = mcr_q[`UEC_MCR_SEL_DTR];
	wire fill_z  = (fill_q == `UEC_RST_ZERO);

	uec_hyst u_hyst (
		.table_sel_i (feature_q[7:6]),
		.hyst_code_i (feature_q[3:0]),
		.trig_i      (trig_q),
		.next_up_i   (rx_next_up_i),
		.next_dn_i   (rx_next_dn_i),
		.up_o        (th_up),
		.dn_o        (th_dn)
	);

	// Two-flop synchronisers for the pins
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end else begin
			sync1_q <= {dsr_n_i, cts_n_i, irda_rx_i};
			sync2_q <= sync1_q;
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		rdat = 32'h0000_0000;
		case (wb_adr_i)
		`UEC_OFS_SCRATCH:   rdat[7:0] = scratch_q;
		`UEC_OFS_FEATURE:   rdat[7:0] = feature_q;
		`UEC_OFS_ENH_SEL:   rdat[7:0] = enh_q;
		`UEC_OFS_TX_FILL:   rdat[7:0] = fill_q;
		`UEC_OFS_INT_EN:    rdat[7:0] = ier_q;
		`UEC_OFS_FIFO_CTL:  rdat[7:0] = fcr_q;
		`UEC_OFS_MODEM_CTL: rdat[7:0] = mcr_q;
		`UEC_OFS_INT_STAT:  rdat[7:0] = {2'b00, pause_st_q, spec_q, 2'b00, rx_trig_o, tx_irq_o};
		`UEC_OFS_RESUME1:   rdat[7:0] = res1_q;
		`UEC_OFS_RESUME2:   rdat[7:0] = res2_q;
		`UEC_OFS_PAUSE1:    rdat[7:0] = pau1_q;
		`UEC_OFS_PAUSE2:    rdat[7:0] = pau2_q;
		`UEC_OFS_TURN_DLY:  rdat[7:0] = {dly_q, 4'h0};
		`UEC_OFS_RX_TRIG:   rdat[7:0] = {1'b0, trig_q};
		default:            rdat = 32'h0000_0000;
		endcase
	end

	// Bus answer: one-cycle ack, every address answered
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= rdat;
		end
	end

	// Software registers; protected bits follow the enable bit
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scratch_q <= `UEC_RST_SCRATCH;
			feature_q <= `UEC_RST_ZERO;
			enh_q     <= `UEC_RST_ZERO;
			ier_q     <= `UEC_RST_ZERO;
			fcr_q     <= `UEC_RST_ZERO;
			mcr_q     <= `UEC_RST_ZERO;
			res1_q    <= `UEC_RST_ZERO;
			res2_q    <= `UEC_RST_ZERO;
			pau1_q    <= `UEC_RST_ZERO;
			pau2_q    <= `UEC_RST_ZERO;
			dly_q     <= 4'h0;
			trig_q    <= 7'h00;
		end else if (wr) begin
			case (wb_adr_i)
			`UEC_OFS_SCRATCH:   scratch_q <= wd;
			`UEC_OFS_FEATURE:   feature_q <= wd;
			`UEC_OFS_ENH_SEL:   enh_q     <= wd;
			`UEC_OFS_INT_EN:    ier_q <= merge(ier_q, wd, `UEC_MASK_IER, unlock);
			`UEC_OFS_FIFO_CTL:  fcr_q <= merge(fcr_q, wd, `UEC_MASK_FCR, unlock);
			`UEC_OFS_MODEM_CTL: mcr_q <= merge(mcr_q, wd, `UEC_MASK_MCR, unlock);
			`UEC_OFS_RESUME1:   res1_q    <= wd;
			`UEC_OFS_RESUME2:   res2_q    <= wd;
			`UEC_OFS_PAUSE1:    pau1_q    <= wd;
			`UEC_OFS_PAUSE2:    pau2_q    <= wd;
			`UEC_OFS_TURN_DLY:  dly_q     <= unlock ? wd[7:4] : dly_q;
			`UEC_OFS_RX_TRIG:   trig_q    <= (wd > FILL_MAX) ? FILL_MAX[6:0] : wd[6:0];
			default:            scratch_q <= scratch_q;
			endcase
		end
	end

	// Transmit fill count; simultaneous push and pop cancel
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			fill_q <= `UEC_RST_ZERO;
		else if (tx_push_i && !tx_pop_i && fill_q != FILL_MAX)
			fill_q <= fill_q + 8'h01;
		else if (tx_pop_i && !tx_push_i && !fill_z)
			fill_q <= fill_q - 8'h01;
	end

	// Half-duplex direction: a load cancels any pending turnaround
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hd_q     <= HD_IDLE;
			hd_cnt_q <= 4'h0;
		end else if (!hdx) begin
			hd_q     <= HD_IDLE;
			hd_cnt_q <= 4'h0;
		end else begin
			case (hd_q)
			HD_IDLE: begin
				if (tx_push_i)
					hd_q <= HD_SEND;
			end
			HD_SEND: begin
				if (tx_char_done_i && fill_z && !tx_push_i) begin
					hd_cnt_q <= dly_q;
					hd_q     <= (dly_q == 4'h0) ? HD_IDLE : HD_WAIT;
				end
			end
			HD_WAIT: begin
				if (tx_push_i)
					hd_q <= HD_SEND;
				else if (bit_tick_i) begin
					hd_cnt_q <= hd_cnt_q - 4'h1;
					if (hd_cnt_q == 4'h1)
						hd_q <= HD_IDLE;
				end
			end
			default: hd_q <= HD_IDLE;
			endcase
		end
	end

	// Receive threshold hold: set at upper, cleared below lower
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			hold_q <= 1'b0;
		else if (!enh_q[`UEC_ENH_AUTO_RTS])
			hold_q <= 1'b0;
		else if (rx_level_i >= th_up)
			hold_q <= 1'b1;
		else if (rx_level_i < th_dn)
			hold_q <= 1'b0;
	end

	// Pins and level outputs, all from flops
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rts_n_o   <= 1'b1;
			dtr_n_o   <= 1'b1;
			irda_rx_o <= 1'b0;
			tx_go_o   <= 1'b0;
			tx_irq_o  <= 1'b0;
			rx_trig_o <= 1'b0;
		end else begin
			// Half-duplex owns RTS; otherwise software level, pulled high by hold unless DTR is selected
			if (hdx)
				rts_n_o <= (hd_q != HD_IDLE);
			else
				rts_n_o <= ~(mcr_q[1] & ~(hold_q & ~sel_dtr));
			dtr_n_o   <= ~(mcr_q[0] & ~(hold_q & sel_dtr));
			irda_rx_o <= irda_s ^ feature_q[`UEC_FCT_IR_INV];
			// The core samples tx_go_o only before a start bit
			tx_go_o   <= ~(enh_q[`UEC_ENH_AUTO_CTS] & (sel_dtr ? dsr_s : cts_s));
			if (hdx)
				tx_irq_o <= fill_z & ~tx_busy_i & ~tx_push_i;
			else
				tx_irq_o <= fill_z & ~tx_push_i;
			rx_trig_o <= (rx_level_i >= trig_q);
		end
	end

	// Register copies for the core
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_en_o       <= `UEC_RST_ZERO;
			fifo_ctl_o     <= `UEC_RST_ZERO;
			modem_ctl_o    <= `UEC_RST_ZERO;
			table_sel_o    <= 2'b00;
			tx_flow_mode_o <= 2'b00;
		end else begin
			int_en_o       <= ier_q;
			fifo_ctl_o     <= fcr_q;
			modem_ctl_o    <= mcr_q;
			table_sel_o    <= feature_q[7:6];
			tx_flow_mode_o <= enh_q[3:2];
		end
	end

	// Receive character classification
	reg [1:0] rxm;
	reg       dual;
	reg       is_res;
	reg       is_pau;
	reg       eat;
	reg [1:0] seq_d;
	always @* begin
		rxm    = enh_q[1:0];
		// Both receive bits: sequence unless one transmit pair chosen
		dual   = (rxm == 2'b11) && (enh_q[3:2] == 2'b11 || enh_q[3:2] == 2'b00);
		is_res = 1'b0;
		is_pau = 1'b0;
		eat    = 1'b0;
		seq_d  = SQ_NONE;
		case (rxm)
		2'b10: begin
			is_res = (rx_char_i == res1_q);
			is_pau = (rx_char_i == pau1_q);
			eat    = is_res | is_pau;
		end
		2'b01: begin
			is_res = (rx_char_i == res2_q);
			is_pau = (rx_char_i == pau2_q);
			eat    = is_res | is_pau;
		end
		2'b11: begin
			if (!dual) begin
				is_res = (rx_char_i == res1_q) | (rx_char_i == res2_q);
				is_pau = (rx_char_i == pau1_q) | (rx_char_i == pau2_q);
				eat    = is_res | is_pau;
			end else if (seq_q == SQ_RESUME && rx_char_i == res2_q) begin
				is_res = 1'b1;
				eat    = 1'b1;
			end else if (seq_q == SQ_PAUSE && rx_char_i == pau2_q) begin
				is_pau = 1'b1;
				eat    = 1'b1;
			end else if (rx_char_i == res1_q) begin
				seq_d = SQ_RESUME;
				eat   = 1'b1;
			end else if (rx_char_i == pau1_q) begin
				seq_d = SQ_PAUSE;
				eat   = 1'b1;
			end
		end
		default: eat = 1'b0;
		endcase
	end

	wire special = enh_q[`UEC_ENH_SPECIAL] & (rx_char_i == pau2_q);
	wire st_clr  = wr & (wb_adr_i == `UEC_OFS_INT_STAT) & unlock;

	// Receive pulses, sequence state and sticky status; set beats clear
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seq_q           <= SQ_NONE;
			rx_store_o      <= 1'b0;
			rx_store_data_o <= `UEC_RST_ZERO;
			rx_resume_o     <= 1'b0;
			rx_pause_o      <= 1'b0;
			spec_q          <= 1'b0;
			pause_st_q      <= 1'b0;
		end else begin
			rx_store_o  <= rx_valid_i & ~eat;
			rx_resume_o <= rx_valid_i & is_res;
			rx_pause_o  <= rx_valid_i & is_pau;
			if (rx_valid_i) begin
				rx_store_data_o <= rx_char_i;
				seq_q           <= seq_d;
			end
			if (rx_valid_i && special)
				spec_q <= 1'b1;
			else if (st_clr && wd[`UEC_ST_SPECIAL])
				spec_q <= 1'b0;
			if (rx_valid_i && is_pau)
				pause_st_q <= 1'b1;
			else if (st_clr && wd[`UEC_ST_PAUSE])
				pause_st_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== tb/uec_ctrl_monitor.sv ====
// Purpose: port checks of uec_ctrl
// Assumes: masters hold a request until ack
// Notes: bound to every uec_ctrl instance
`include "uec_map.vh"
`default_nettype none
module uec_ctrl_chk #(
	parameter FILL_MAX = 8'h40
) (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rx_valid_i,
	input wire logic [7:0]  rx_char_i,
	input wire logic        rx_store_o,
	input wire logic [7:0]  rx_store_data_o,
	input wire logic        rx_pause_o,
	input wire logic [7:0]  int_en_o,
	input wire logic [7:0]  fifo_ctl_o,
	input wire logic [7:0]  modem_ctl_o,
	input wire logic        cts_n_i,
	input wire logic        dsr_n_i,
	input wire logic        tx_go_o,
	input wire logic        rts_n_o,
	input wire logic        dtr_n_o
);
	// A request counts only while no ack stands
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic [8:0] prot = {int_en_o[7:4], fifo_ctl_o[5:4], modem_ctl_o[7:5]};
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_ack_follows:
		assert property (req |=> wb_ack_o) else $error("no ack");
	a_ack_single:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_fill_cap:
		assert property (wb_ack_o && wb_adr_i == `UEC_OFS_TX_FILL
			|-> wb_dat_o[15:0] <= FILL_MAX) else $error("fill over limit");
	a_reset_state:
		assert property ($rose(rst_n_i) |-> rts_n_o && dtr_n_o && prot == 9'h000)
			else $error("bad reset state");
	a_prot_write:
		assert property ($changed(prot) |-> $past(req, 2)) else $error("lock broken");
	a_store_cause:
		assert property (rx_store_o |-> $past(rx_valid_i)
			&& rx_store_data_o == $past(rx_char_i)) else $error("bad store");
	a_pause_cause:
		assert property (rx_pause_o |-> $past(rx_valid_i) && !rx_store_o)
			else $error("bad pause");
	a_cts_stops:
		assert property ($past(rst_n_i, 4) && !tx_go_o |-> $past(cts_n_i, 3)
			|| $past(cts_n_i, 4) || $past(dsr_n_i, 3) || $past(dsr_n_i, 4))
			else $error("halt without flow pin");
	c_store: cover property (rx_store_o);
	c_pause: cover property (rx_pause_o);
	c_halt: cover property (!tx_go_o);
endmodule

bind uec_ctrl uec_ctrl_chk #(.FILL_MAX(FILL_MAX)) u_chk (
	.sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
	.rx_valid_i, .rx_char_i, .rx_store_o, .rx_store_data_o, .rx_pause_o, .int_en_o,
	.fifo_ctl_o, .modem_ctl_o, .cts_n_i, .dsr_n_i, .tx_go_o, .rts_n_o, .dtr_n_o
);
`default_nettype wire

// ==== tb/uec_peer.sv ====
// Purpose: far-side serial device on flow and infrared lines
// Assumes: lines move just after a rising edge
// Notes: a stop request raises both flow lines
`default_nettype none
module uec_peer (
	input  wire logic sys_clk_i,
	input  wire logic stop_i,
	input  wire logic ir_i,
	output var logic  cts_n_o,
	output var logic  dsr_n_o,
	output var logic  irda_o
);
	// Registered so pins never change on the sampling instant
	always @(posedge sys_clk_i) begin
		cts_n_o <= stop_i;
		dsr_n_o <= stop_i;
		irda_o  <= ir_i;
	end
endmodule
`default_nettype wire

// ==== tb/test_uec_ctrl.sv ====
// Purpose: register and pin test of uec_ctrl
// Assumes: drive on rising edges; bus answers taken at the ack edge, pins on falling edges
// Notes: pin paths lag up to four cycles, so waits are generous
`include "uec_map.vh"
`default_nettype none
module test_uec_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [5:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic        tx_push_i, tx_pop_i, tx_busy_i, tx_char_done_i, bit_tick_i, tx_go_o;
	logic        tx_irq_o, rx_valid_i, rx_store_o, rx_pause_o, stop, ir;
	logic [7:0]  rx_char_i, rx_store_data_o, int_en_o, fifo_ctl_o, modem_ctl_o, q;
	logic [6:0]  rx_level_i, rx_next_up_i, rx_next_dn_i;
	logic        irda_rx_i, cts_n_i, dsr_n_i, irda_rx_o, rts_n_o, dtr_n_o;
	logic        rx_resume_o, rx_trig_o;
	logic [1:0]  tx_flow_mode_o, table_sel_o;
	int          mismatches, cmp_count, cycles, i;
	logic [5:0]  ofs [3] = '{`UEC_OFS_INT_EN, `UEC_OFS_FIFO_CTL, `UEC_OFS_MODEM_CTL};
	logic [7:0]  msk [3] = '{`UEC_MASK_IER, `UEC_MASK_FCR, `UEC_MASK_MCR};
	logic [7:0]  flw [4] = '{8'h12, 8'h11, 8'h1b, 8'h1b};
	logic [7:0]  fch [4] = '{8'h93, 8'h93, 8'h93, 8'h7e};
	logic [7:0]  fex [4] = '{8'h01, 8'h02, 8'h01, 8'h01};
	logic [7:0]  hft [5] = '{8'h01, 8'h01, 8'hc1, 8'hc1, 8'hc1};
	logic [6:0]  hlv [5] = '{7'h0a, 7'h03, 7'h14, 7'h0c, 7'h0b};
	// Bits: [3:2] table select, [1] trigger reached, [0] flow pin
	logic [7:0]  hrt [5] = '{8'h01, 8'h00, 8'h0f, 8'h0d, 8'h0c};

	uec_ctrl #(.FILL_MAX(8'h40)) DUT (
		.sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_dat_o, .wb_ack_o, .tx_push_i, .tx_pop_i, .tx_busy_i,
		.tx_char_done_i, .bit_tick_i, .tx_go_o, .tx_irq_o, .tx_flow_mode_o,
		.rx_valid_i, .rx_char_i, .rx_level_i, .rx_next_up_i, .rx_next_dn_i,
		.rx_store_o, .rx_store_data_o, .rx_resume_o, .rx_pause_o, .rx_trig_o,
		.int_en_o, .fifo_ctl_o, .modem_ctl_o, .table_sel_o, .irda_rx_i, .cts_n_i,
		.dsr_n_i, .irda_rx_o, .rts_n_o, .dtr_n_o
	);
	uec_peer PEER (
		.sys_clk_i, .stop_i(stop), .ir_i(ir), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i),
		.irda_o(irda_rx_i)
	);

	// Clock at 50 MHz
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// Hang guard: the tests need well under a thousand cycles
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single cycle, held until ack is seen
	// Only the hang guard ends a wait for ack; data is taken at the ack edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do
			@(posedge sys_clk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	// k holds tick, pop and push; each stays up for n cycles
	task automatic strb(input logic [2:0] k, input int n);
		@(posedge sys_clk_i);
		{bit_tick_i, tx_pop_i, tx_push_i} <= k;
		repeat (n) @(posedge sys_clk_i);
		{bit_tick_i, tx_pop_i, tx_push_i} <= 3'b000;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic rx(input logic [7:0] c);
		@(posedge sys_clk_i);
		rx_valid_i <= 1'b1;
		rx_char_i <= c;
		@(posedge sys_clk_i);
		rx_valid_i <= 1'b0;
		@(negedge sys_clk_i);
		q = {5'h00, rx_resume_o, rx_store_o, rx_pause_o};
	endtask
	task automatic fin();
		@(posedge sys_clk_i);
		{tx_busy_i, tx_char_done_i} <= 2'b01;
		@(posedge sys_clk_i);
		tx_char_done_i <= 1'b0;
	endtask
	task automatic close_out();
		$display("compares=%0d mismatches=%0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, stop, rst_n_i} = 6'h00;
		{tx_push_i, tx_pop_i, tx_busy_i, tx_char_done_i, bit_tick_i} = 5'h00;
		{wb_adr_i, wb_dat_i, rx_char_i, ir} = 47'h0;
		wb_sel_i = 4'h1;
		{rx_level_i, rx_next_up_i, rx_next_dn_i} = {7'h00, 7'h08, 7'h04};
		{mismatches, cmp_count, cycles} = 96'h0;
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(`UEC_OFS_SCRATCH, 8'hff);
		rd(`UEC_OFS_FEATURE, 8'h00);
		rd(`UEC_OFS_ENH_SEL, 8'h00);
		wr(`UEC_OFS_SCRATCH, 8'h5a);
		rd(`UEC_OFS_SCRATCH, 8'h5a);
		rd(6'h3c, 8'h00);
		for (i = 0; i < 3; i++) begin
			rd(ofs[i], 8'h00);
			wr(ofs[i], 8'hff);
			rd(ofs[i], ~msk[i]);
			wr(`UEC_OFS_ENH_SEL, 8'h10);
			wr(ofs[i], 8'hff);
			rd(ofs[i], 8'hff);
			wr(`UEC_OFS_ENH_SEL, 8'h00);
			wr(ofs[i], 8'h00);
			rd(ofs[i], msk[i]);
		end
		chk(int_en_o, `UEC_MASK_IER);
		chk(fifo_ctl_o, `UEC_MASK_FCR);
		chk(modem_ctl_o, `UEC_MASK_MCR);
		// Fill count, then saturation and drain
		strb(3'b001, 3);
		rd(`UEC_OFS_TX_FILL, 8'h03);
		strb(3'b001, 70);
		rd(`UEC_OFS_TX_FILL, 8'h40);
		strb(3'b010, 80);
		rd(`UEC_OFS_TX_FILL, 8'h00);
		// Infrared polarity for both pin levels
		for (i = 0; i < 4; i++) begin
			wr(`UEC_OFS_FEATURE, i[1] ? 8'h10 : 8'h00);
			@(posedge sys_clk_i);
			ir <= i[0];
			settle(6);
			chk({7'h00, irda_rx_o}, {7'h00, i[0] ^ i[1]});
		end
		// Transmit interrupt source and half duplex direction
		strb(3'b001, 1);
		strb(3'b010, 1);
		@(posedge sys_clk_i);
		tx_busy_i <= 1'b1;
		settle(4);
		chk({7'h00, tx_irq_o}, 8'h01);
		wr(`UEC_OFS_FEATURE, 8'h20);
		settle(4);
		chk({7'h00, tx_irq_o}, 8'h00);
		fin();
		settle(4);
		chk({6'h00, rts_n_o, tx_irq_o}, 8'h01);
		wr(`UEC_OFS_ENH_SEL, 8'h10);
		wr(`UEC_OFS_TURN_DLY, 8'h20);
		strb(3'b001, 1);
		settle(4);
		chk({7'h00, rts_n_o}, 8'h01);
		strb(3'b010, 1);
		fin();
		settle(6);
		chk({7'h00, rts_n_o}, 8'h01);
		strb(3'b100, 2);
		settle(4);
		chk({7'h00, rts_n_o}, 8'h00);
		// Special character, alone and with second-pair compare
		wr(`UEC_OFS_PAUSE1, 8'h93);
		wr(`UEC_OFS_PAUSE2, 8'h7e);
		wr(`UEC_OFS_ENH_SEL, 8'h30);
		rx(8'h7e);
		chk(q, 8'h02);
		chk(rx_store_data_o, 8'h7e);
		bus(1'b0, `UEC_OFS_INT_STAT, 8'h00);
		chk(q & 8'h30, 8'h10);
		wr(`UEC_OFS_INT_STAT, 8'h30);
		wr(`UEC_OFS_ENH_SEL, 8'h00);
		wr(`UEC_OFS_ENH_SEL, 8'h31);
		rx(8'h7e);
		chk(q, 8'h01);
		bus(1'b0, `UEC_OFS_INT_STAT, 8'h00);
		chk(q & 8'h30, 8'h30);
		// Receive compare modes
		for (i = 0; i < 4; i++) begin
			wr(`UEC_OFS_ENH_SEL, 8'h00);
			wr(`UEC_OFS_ENH_SEL, flw[i]);
			rx(fch[i]);
			chk(q, fex[i]);
			chk({6'h00, tx_flow_mode_o}, {6'h00, flw[i][3:2]});
		end
		wr(`UEC_OFS_ENH_SEL, 8'h00);
		wr(`UEC_OFS_ENH_SEL, 8'h1f);
		rx(8'h93);
		chk(q, 8'h00);
		rx(8'h7e);
		chk(q, 8'h01);
		rx(8'h00);
		chk(q, 8'h00);
		rx(8'h00);
		chk(q, 8'h04);
		// Auto CTS halts and resumes the transmitter
		wr(`UEC_OFS_ENH_SEL, 8'h80);
		@(posedge sys_clk_i);
		stop <= 1'b1;
		settle(6);
		chk({7'h00, tx_go_o}, 8'h00);
		@(posedge sys_clk_i);
		stop <= 1'b0;
		settle(6);
		chk({7'h00, tx_go_o}, 8'h01);
		// Software RTS, then automatic thresholds
		wr(`UEC_OFS_FEATURE, 8'h00);
		wr(`UEC_OFS_ENH_SEL, 8'h00);
		wr(`UEC_OFS_MODEM_CTL, 8'h02);
		settle(4);
		chk({6'h00, dtr_n_o, rts_n_o}, 8'h02);
		wr(`UEC_OFS_RX_TRIG, 8'h10);
		wr(`UEC_OFS_ENH_SEL, 8'h40);
		for (i = 0; i < 5; i++) begin
			wr(`UEC_OFS_FEATURE, hft[i]);
			@(posedge sys_clk_i);
			rx_level_i <= hlv[i];
			settle(5);
			chk({4'h0, table_sel_o, rx_trig_o, rts_n_o}, hrt[i]);
		end
		close_out();
	end
endmodule
`default_nettype wire
